// file: core/cptt_pkg.sv
package cptt_pkg;

  // Leaf entry bit positions for the 39/48/57-bit schemes
  localparam int unsigned PTE_CD_BIT    = 61;
  localparam int unsigned PTE_CW_BIT    = 60;
  localparam int unsigned PTE_V_BIT     = 0;
  localparam int unsigned PTE_R_BIT     = 1;
  localparam int unsigned PTE_W_BIT     = 2;
  localparam int unsigned PTE_LEAF_W    = 64;

  // Environment configuration enable bit position
  localparam int unsigned ENV_CDE_BIT   = 61;

  // Register byte offsets on the AHB-Lite slave
  localparam logic [7:0] OFF_ENVCFG_LO  = 8'h00;
  localparam logic [7:0] OFF_ENVCFG_HI  = 8'h04;
  localparam logic [7:0] OFF_SCHEME     = 8'h08;
  localparam logic [7:0] OFF_STATUS     = 8'h0C;
  localparam logic [7:0] OFF_FAULTCNT   = 8'h10;
  localparam logic [7:0] OFF_UPDCNT     = 8'h14;

  // Reset values
  localparam logic [63:0] ENVCFG_RESET  = 64'h0000_0000_0000_0000;
  localparam logic [2:0]  SCHEME_RESET  = 3'h0;

  // Scheme control bit positions
  localparam int unsigned SCH_CW_STRIP  = 0; // 1: strip tag instead of fault
  localparam int unsigned SCH_CD_UPDATE = 1; // 1: set dirty instead of fault
  localparam int unsigned SCH_CD_CFG    = 2; // 1: enable bit is writable

  // Store request from the load/store pipeline
  typedef struct packed {
    logic [63:0] vaddr;    // Store virtual address
    logic [63:0] pte;      // Leaf entry from walker
    logic [55:0] pte_addr; // Physical address of leaf entry
    logic        cap_st;   // Capability store or AMO
    logic        auth_w;   // Authority grants write
    logic        auth_c;   // Authority grants capability
    logic        tag;      // Tag of stored capability
    logic        smode;    // Supervisor-mode translation
  } cptt_req_type;

  // Verdict back to the pipeline
  typedef struct packed {
    logic fault;     // Store page fault
    logic clear_tag; // Strip tag of stored value
  } cptt_rsp_type;

  // Checker state machine, Gray coded
  typedef enum logic [1:0] {
    CPTT_IDLE  = 2'b00,
    CPTT_READ  = 2'b01,
    CPTT_WRITE = 2'b11,
    CPTT_DONE  = 2'b10
  } cptt_state_type;

endpackage

// file: core/cptt_ahb_slave.sv
`timescale 1ns/1ps
module cptt_ahb_slave
  import cptt_pkg::*;
(
  input  wire logic        hclk,      // Bus clock
  input  wire logic        hresetn,   // Async reset, active low
  input  wire logic        hsel,      // Slave select
  input  wire logic [31:0] haddr,     // Byte address
  input  wire logic [1:0]  htrans,    // Transfer type
  input  wire logic        hwrite,    // Write strobe
  input  wire logic [2:0]  hsize,     // Transfer size
  input  wire logic        hready,    // Bus ready in
  output logic             wr_en,     // Register write pulse
  output logic             rd_phase,  // Read data phase
  output logic [7:0]       reg_addr,  // Latched offset
  output logic             hreadyout, // Always ready
  output logic             hresp      // Always OKAY
);

  logic       act_q;  // Data phase pending
  logic       wr_q;   // Pending is a write
  logic [7:0] addr_q; // Pending offset

  // Capture address phase on a valid accepted transfer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      act_q  <= 1'b0;
      wr_q   <= 1'b0;
      addr_q <= 8'h00;
    end else if (hready) begin
      act_q  <= hsel && htrans[1] && (hsize == 3'h2);
      wr_q   <= hwrite;
      addr_q <= haddr[7:0];
    end
  end

  // Zero wait-state slave
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign wr_en     = act_q && wr_q;
  assign rd_phase  = act_q && !wr_q;
  assign reg_addr  = addr_q;

endmodule // cptt_ahb_slave

// file: core/cptt_top.sv
// Functional notes
// R01 - Dirty bit 61, write-allow bit 60
// R02 - Write-allow flag gates tagged capability stores
// R03 - Faulting scheme: clear write-allow faults
// R04 - Stripping scheme: store proceeds, tag cleared
// R05 - Write-allow always present, tag independent
// R06 - Dirty flag marks tagged store since clear
// R07 - Dirty support optional, two schemes
// R08 - Faulting dirty scheme: clear dirty faults
// R09 - Updating scheme sets dirty in entry
// R10 - Update atomic, recheck valid and permissions
// R11 - Never speculative, program order locally
// R12 - Update ordered before triggering store
// R13 - Fences order the associated entry updates
// R14 - Store waits for visible update
// R15 - Hold access until entry write observed
// R16 - Clear write-allow suppresses dirty handling
// R17 - Enable bit 61 of environment config
// R18 - Enable set exposes dirty to S-mode
// R19 - Enable clear acts as unimplemented
// R20 - No dirty support: enable reads zero
// R21 - Fixed dirty support: enable reads one
`timescale 1ns/1ps
module cptt_top
  import cptt_pkg::*;
#(
  parameter bit CD_IMPL = 1'b1, // Dirty flag implemented
  parameter bit CD_CFG  = 1'b1  // Enable bit software writable
) (
  input  wire logic         hclk,       // Clock, 200 MHz
  input  wire logic         hresetn,    // Async reset, active low
  input  wire logic         hsel,       // AHB select
  input  wire logic [31:0]  haddr,      // AHB address
  input  wire logic [1:0]   htrans,     // AHB transfer type
  input  wire logic         hwrite,     // AHB write
  input  wire logic [2:0]   hsize,      // AHB size
  input  wire logic         hready,     // AHB ready in
  input  wire logic [31:0]  hwdata,     // AHB write data
  output logic [31:0]       hrdata,     // AHB read data
  output logic              hreadyout,  // AHB ready out
  output logic              hresp,      // AHB response
  input  wire logic         req_valid,  // Store check request
  output logic              req_ready,  // Checker idle
  input  wire cptt_req_type req,        // Request fields
  output logic              rsp_valid,  // Verdict pulse
  output cptt_rsp_type      rsp,        // Verdict fields
  output logic              mem_req,    // Entry memory access
  output logic              mem_we,     // Entry write
  output logic              mem_lock,   // Hold entry atomically
  output logic [55:0]       mem_addr,   // Entry address
  output logic [63:0]       mem_wdata,  // Entry write data
  input  wire logic         mem_ack,    // Access done, write globally visible
  input  wire logic [63:0]  mem_rdata   // Entry read data
);

  logic           wr_en;       // Register write pulse
  logic           rd_phase;    // Register read phase
  logic [7:0]     reg_addr;    // Register offset
  logic [63:0]    envcfg_q;    // Environment config storage
  logic [2:0]     scheme_q;    // Scheme selection
  logic [31:0]    faultcnt_q;  // Faults raised
  logic [31:0]    updcnt_q;    // Dirty updates done
  logic           cde;         // Effective dirty enable
  cptt_state_type state_q;     // Checker state
  cptt_state_type state_d;     // Next checker state
  cptt_req_type   req_q;       // Captured request
  logic [63:0]    pte_q;       // Re-read entry
  cptt_rsp_type   rsp_q;       // Verdict register
  logic           rsp_valid_q; // Verdict valid
  logic           qual;        // Capability store qualified, tag not checked
  logic           cw_ok;       // Write-allow set
  logic           cd_live;     // Dirty handling active
  logic           need_upd;    // Dirty must be set
  logic           rd_ok;       // Re-read entry still grants

  // Bus protocol handling lives in the small slave
  cptt_ahb_slave u_slave (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hsize     (hsize),
    .hready    (hready),
    .wr_en     (wr_en),
    .rd_phase  (rd_phase),
    .reg_addr  (reg_addr),
    .hreadyout (hreadyout),
    .hresp     (hresp)
  );

  // Enable bit: hardwired unless implemented and configurable
  always_comb begin
    if (!CD_IMPL) begin
      cde = 1'b0; // R20
    end else if (!CD_CFG) begin
      cde = 1'b1; // R21
    end else begin
      cde = envcfg_q[ENV_CDE_BIT]; // R17
    end
  end

  // Environment config; only the enable bit is stored here
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      envcfg_q <= ENVCFG_RESET;
    end else if (wr_en && reg_addr == OFF_ENVCFG_HI && CD_IMPL && CD_CFG) begin
      envcfg_q[ENV_CDE_BIT] <= hwdata[ENV_CDE_BIT - 32]; // R17
    end
  end

  // Scheme selection written by software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scheme_q <= SCHEME_RESET;
    end else if (wr_en && reg_addr == OFF_SCHEME) begin
      scheme_q <= hwdata[2:0]; // R07
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    hrdata = 32'h0000_0000;
    if (rd_phase) begin
      unique case (reg_addr)
        OFF_ENVCFG_LO: hrdata = envcfg_q[31:0];
        OFF_ENVCFG_HI: hrdata = {2'b00, cde, 29'h0000_0000};
        OFF_SCHEME:    hrdata = {29'h0000_0000, CD_CFG, scheme_q[1:0]};
        OFF_STATUS:    hrdata = {29'h0000_0000, CD_IMPL, state_q};
        OFF_FAULTCNT:  hrdata = faultcnt_q;
        OFF_UPDCNT:    hrdata = updcnt_q;
        default:       hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Qualification of the captured request
  // Write-allow check ignores the tag, dirty checks need tag set
  assign cw_ok    = req_q.pte[PTE_CW_BIT]; // R01 R02 R05
  assign qual     = req_q.cap_st && req_q.auth_w && req_q.auth_c;
  // Dirty handling only with write-allow set and enable on in S-mode
  assign cd_live  = CD_IMPL && cw_ok && (cde || !req_q.smode); // R16 R18 R19
  assign need_upd = qual && req_q.tag && cd_live && !req_q.pte[PTE_CD_BIT]; // R06
  assign rd_ok    = mem_rdata[PTE_V_BIT] && mem_rdata[PTE_W_BIT] && mem_rdata[PTE_CW_BIT];

  // One request at a time keeps updates in program order
  assign req_ready = (state_q == CPTT_IDLE); // R11 R13

  // Next state; memory only touched for a committed store
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CPTT_IDLE: begin
        if (req_valid) begin
          state_d = CPTT_DONE;
        end
      end
      CPTT_READ: begin
        if (mem_ack) begin
          state_d = rd_ok ? CPTT_WRITE : CPTT_DONE; // R10
        end
      end
      CPTT_WRITE: begin
        if (mem_ack) begin
          state_d = CPTT_DONE; // R15
        end
      end
      CPTT_DONE: begin
        state_d = CPTT_IDLE;
      end
    endcase
  end

  // State register; DONE on a first pass decides, IDLE->DONE is a decision step
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= CPTT_IDLE;
    end else if (state_q == CPTT_DONE && !rsp_valid_q && need_upd && scheme_q[SCH_CD_UPDATE]) begin
      state_q <= CPTT_READ; // R09
    end else begin
      state_q <= state_d;
    end
  end

  // Request capture
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req_q <= '0;
    end else if (state_q == CPTT_IDLE && req_valid) begin
      req_q <= req;
    end
  end

  // Re-read entry kept for the atomic write-back
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pte_q <= 64'h0000_0000_0000_0000;
    end else if (state_q == CPTT_READ && mem_ack) begin
      pte_q <= mem_rdata;
    end
  end

  // Locked read-modify-write of the entry; store waits for ack
  always_comb begin
    mem_req   = (state_q == CPTT_READ) || (state_q == CPTT_WRITE);
    mem_we    = (state_q == CPTT_WRITE);
    mem_lock  = mem_req; // R10
    mem_addr  = req_q.pte_addr;
    mem_wdata = pte_q | (64'h1 << PTE_CD_BIT); // R09
  end

  // Verdict: issued once decision or update completes, never before visibility
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rsp_valid_q <= 1'b0;
      rsp_q       <= '0;
    end else begin
      rsp_valid_q <= 1'b0;
      if (state_q == CPTT_DONE && !rsp_valid_q) begin
        if (!(need_upd && scheme_q[SCH_CD_UPDATE])) begin
          rsp_valid_q     <= 1'b1;
          rsp_q.fault     <= (qual && !cw_ok && !scheme_q[SCH_CW_STRIP]) // R03
                          || (need_upd && !scheme_q[SCH_CD_UPDATE]);    // R08
          rsp_q.clear_tag <= qual && !cw_ok && scheme_q[SCH_CW_STRIP];  // R04
        end
      end else if (state_q == CPTT_READ && mem_ack && !rd_ok) begin
        rsp_valid_q     <= 1'b1; // Entry changed: fault, no update
        rsp_q.fault     <= 1'b1;
        rsp_q.clear_tag <= 1'b0;
      end else if (state_q == CPTT_WRITE && mem_ack) begin
        rsp_valid_q     <= 1'b1; // R12 R14
        rsp_q.fault     <= 1'b0;
        rsp_q.clear_tag <= 1'b0;
      end
    end
  end

  assign rsp_valid = rsp_valid_q;
  assign rsp       = rsp_q;

  // Event counters, visible to software
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      faultcnt_q <= 32'h0000_0000;
      updcnt_q   <= 32'h0000_0000;
    end else begin
      if (rsp_valid_q && rsp_q.fault) begin
        faultcnt_q <= faultcnt_q + 32'h0000_0001;
      end
      if (state_q == CPTT_WRITE && mem_ack) begin
        updcnt_q <= updcnt_q + 32'h0000_0001;
      end
    end
  end

endmodule // cptt_top

// file: verif/cptt_top_sva.sv
`timescale 1ns/1ps
module cptt_top_sva
  import cptt_pkg::*;
(
  input wire logic         hclk,      // Clock
  input wire logic         hresetn,   // Reset, active low
  input wire logic         req_valid, // Request present
  input wire logic         req_ready, // Checker idle
  input wire cptt_req_type req,       // Request
  input wire logic         rsp_valid, // Verdict pulse
  input wire cptt_rsp_type rsp,       // Verdict
  input wire logic         mem_req,   // Entry access
  input wire logic         mem_we,    // Entry write
  input wire logic         mem_lock,  // Entry held
  input wire logic [55:0]  mem_addr,  // Entry address
  input wire logic [63:0]  mem_wdata, // Entry data
  input wire logic         mem_ack    // Access done
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Steps of one check
  sequence s_take; req_valid && req_ready; endsequence
  sequence s_rd_ack; mem_req && !mem_we && mem_ack; endsequence
  sequence s_wr_ack; mem_we && mem_ack; endsequence
  chk_first_step: assert property (s_take |-> ##2 (rsp_valid || mem_req))
    else $error("check gave no step two cycles after take");
  chk_cw_clear: assert property (s_take ##0 !req.pte[PTE_CW_BIT] |-> ##2 rsp_valid && !mem_req)
    else $error("entry touched with write-allow clear");
  chk_busy_refuse: assert property (s_take |=> !req_ready)
    else $error("second request accepted while busy");
  chk_rd_locked: assert property (mem_req && !mem_we |-> mem_lock)
    else $error("entry read without lock");
  chk_req_held: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_we) && $stable(mem_addr))
    else $error("entry access dropped before ack");
  chk_rd_then: assert property (s_rd_ack |-> ##[1:2] (mem_we || (rsp_valid && rsp.fault)))
    else $error("no write or fault after entry read");
  chk_wr_sets_cd: assert property (mem_we |-> mem_wdata[PTE_CD_BIT] && mem_wdata[PTE_CW_BIT])
    else $error("entry write without dirty flag");
  chk_wr_after_rd: assert property ($rose(mem_we) |-> $past(mem_ack))
    else $error("entry write without prior read");
  chk_visible_first: assert property (s_wr_ack |=> rsp_valid && !rsp.fault)
    else $error("verdict not right after visible write");
  chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("verdict pulse too long");
endmodule // cptt_top_sva

bind cptt_top cptt_top_sva chk (.hclk, .hresetn, .req_valid, .req_ready, .req, .rsp_valid, .rsp,
  .mem_req, .mem_we, .mem_lock, .mem_addr, .mem_wdata, .mem_ack);

// file: verif/cptt_pte_mem.sv
`timescale 1ns/1ps
module cptt_pte_mem (
  input  wire logic        hclk,      // Clock
  input  wire logic        hresetn,   // Reset, active low
  input  wire logic        mem_req,   // Entry access
  input  wire logic        mem_we,    // Entry write
  input  wire logic [55:0] mem_addr,  // Entry address
  input  wire logic [63:0] mem_wdata, // Entry write data
  input  wire logic [1:0]  delay,     // Extra wait cycles
  output logic             mem_ack,   // Access done
  output logic [63:0]      mem_rdata  // Entry read data
);
  logic [63:0] entry;     // One leaf entry, loaded by the bench
  logic [55:0] addr_seen; // Address of last write
  int          wait_n;    // Cycles waited
  // Write lands at the ack, so ack means globally visible
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_ack <= 1'b0;
      wait_n  <= 0;
    end else if (mem_req && !mem_ack && wait_n >= delay) begin
      mem_ack <= 1'b1;
      wait_n  <= 0;
      if (mem_we) begin
        entry     <= mem_wdata;
        addr_seen <= mem_addr;
      end
    end else begin
      mem_ack <= 1'b0;
      wait_n  <= (mem_req && !mem_ack) ? wait_n + 1 : 0;
    end
  end
  // Junk outside an ack so stale data is never trusted
  assign mem_rdata = mem_ack ? entry : ~entry;
endmodule // cptt_pte_mem

// file: verif/test_capability_pte_tracking.sv
`timescale 1ns/1ps
module test_capability_pte_tracking;
  import cptt_pkg::*;
  logic         hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp; // Bus control
  logic         req_valid, req_ready, rsp_valid, mem_req, mem_we;    // Handshakes
  logic         mem_lock, mem_ack;                                   // Entry side
  logic [55:0]  mem_addr;                                            // Entry address
  logic [63:0]  mem_wdata, mem_rdata;                                // Entry data
  logic [31:0]  haddr, hwdata, hrdata, seed, rd;                     // Bus data
  logic [1:0]   htrans, mem_delay;                                   // Transfer, wait
  logic [2:0]   hsize;                                               // Always word
  cptt_req_type req;                                                 // Request
  cptt_rsp_type rsp;                                                 // Verdict
  int           fail_count, samples_checked;                         // Tallies
  int           exp_faults, exp_upds;                                // Model event counts
  assign hready = hreadyout;
  cptt_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .req_valid(req_valid), .req_ready(req_ready), .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
    .mem_req(mem_req), .mem_we(mem_we), .mem_lock(mem_lock), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  cptt_pte_mem pm (.hclk(hclk), .hresetn(hresetn), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .delay(mem_delay), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  always #2.5 hclk = ~hclk;
  // Verdict and stop
  task automatic wrap_up();
    if (fail_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // One comparison
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    samples_checked++;
    if (s !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Fixed-seed xorshift
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Bounded wait on a flag sampled at the edge
  task automatic wait_for(ref logic f);
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (f !== 1'b1 && n < 200);
    if (n >= 200) begin
      fail_count++;
      wrap_up();
    end
  endtask
  // Single AHB word transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    haddr  <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    wait_for(hready);
    htrans <= 2'h0;
    hwdata <= d;
    wait_for(hready);
    q = hrdata;
  endtask
  // Random check against the reference model
  task automatic check_one();
    cptt_req_type r;
    logic [31:0]  x, y;
    logic [63:0]  ent;
    logic         q, en, ef, ec, up;
    x = rnd();
    y = rnd();
    bus(1'b1, OFF_SCHEME, {30'h0, x[1:0]}, rd);
    bus(1'b1, OFF_ENVCFG_HI, {2'h0, x[2], 29'h0}, rd);
    r = {rnd(), rnd(), rnd(), rnd(), x[31:8], y, y[7:2]};
    ent = r.pte & ~{63'h0, y[9] & y[12]};
    pm.entry = ent;
    mem_delay <= x[4:3];
    q = r.cap_st & r.auth_w & r.auth_c;
    en = !r.smode || x[2];
    ef = 1'b0;
    ec = 1'b0;
    up = 1'b0;
    if (q && !r.pte[PTE_CW_BIT]) begin
      ec = x[0];
      ef = !x[0];
    end else if (q && r.tag && !r.pte[PTE_CD_BIT] && en) begin
      up = x[1];
      ef = !x[1] || !(ent[PTE_V_BIT] && ent[PTE_W_BIT] && ent[PTE_CW_BIT]);
    end
    req <= r;
    req_valid <= 1'b1;
    wait_for(req_ready);
    req_valid <= 1'b0;
    wait_for(rsp_valid);
    chk("fault", ef, rsp.fault);
    chk("clear_tag", ec, rsp.clear_tag);
    chk("entry", (up && !ef) ? ent | 64'h2000_0000_0000_0000 : ent, pm.entry);
    if (up && !ef) chk("entry_addr", r.pte_addr, pm.addr_seen);
    // Software-visible tallies follow the model's verdicts
    exp_faults += ef;
    exp_upds += (up && !ef);
  endtask
  // Main sequence
  initial begin
    {hclk, hresetn, hsel, hwrite, req_valid, haddr, hwdata, htrans, mem_delay} = '0;
    {req, fail_count, samples_checked} = '0;
    exp_faults = 0;
    exp_upds = 0;
    hsize = 3'h2;
    seed = 32'hC9F5_5E0A;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    hsel <= 1'b1;
    bus(1'b0, OFF_ENVCFG_HI, 32'h0, rd);
    chk("env_hi_reset", 32'h0, rd);
    bus(1'b1, OFF_ENVCFG_HI, 32'hFFFF_FFFF, rd);
    bus(1'b0, OFF_ENVCFG_HI, 32'h0, rd);
    chk("env_hi", 32'h2000_0000, rd);
    bus(1'b1, OFF_ENVCFG_LO, 32'hFFFF_FFFF, rd);
    bus(1'b0, OFF_ENVCFG_LO, 32'h0, rd);
    chk("env_lo", 32'h0, rd);
    bus(1'b0, 8'h18, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    repeat (300) check_one();
    bus(1'b0, OFF_FAULTCNT, 32'h0, rd);
    chk("fault_count", exp_faults, rd);
    bus(1'b0, OFF_UPDCNT, 32'h0, rd);
    chk("update_count", exp_upds, rd);
    hresetn <= 1'b0;
    @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, OFF_SCHEME, 32'h0, rd);
    chk("scheme_reset", 32'h4, rd);
    wrap_up();
  end
endmodule // test_capability_pte_tracking
